/* File: board_reset_model.sv */
// Board reset circuit and boot memory model.
// Assumes one clock; pin held low from power-up for HOLD cycles.
`timescale 1ns/10ps
`default_nettype none
module board_reset_model #(parameter int HOLD = 40) (
    input wire logic core_clk,
    input wire logic pulse_req,
    input wire logic [1:0] ack_delay,
    input wire logic [31:0] mode_vec,
    input wire logic [31:0] reset_vec,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output logic pin_n,
    output logic fetch_ack,
    output logic [31:0] fetch_data
);
int low_cnt = HOLD;
int wait_cnt = 0;
initial begin
    pin_n = 1'b0;
    fetch_ack = 1'b0;
    fetch_data = 32'h0;
end
always @(posedge core_clk) begin
    // Power-up and commanded low pulses
    low_cnt <= pulse_req ? HOLD : (low_cnt > 0 ? low_cnt - 1 : 0);
    pin_n <= (low_cnt == 0) && !pulse_req;
    fetch_ack <= 1'b0;
    if (fetch_req && !fetch_ack && wait_cnt >= ack_delay) begin
        fetch_ack <= 1'b1;
        fetch_data <= (fetch_addr == 32'h000ffff8) ? mode_vec : reset_vec;
        wait_cnt <= 0;
    end else begin
        wait_cnt <= fetch_req ? wait_cnt + 1 : 0;
        fetch_data <= ~fetch_data;
    end
end
endmodule
`default_nettype wire

/* File: reset_seq_defines.vh */
// Constants for the reset source collector and release sequencer.
// Assumes a single 40 MHz core clock and a plain register port.

`ifndef RESET_SEQ_DEFINES_VH
`define RESET_SEQ_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_RESET_CAUSE 8'h00
`define OFS_STANDBY_CTRL 8'h04
`define OFS_TIMEBASE_CTRL 8'h08
`define OFS_WD_POSTPONE 8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_CAUSE_PIN 15
`define BIT_CAUSE_WATCHDOG_CAUSE_FLAG 13
`define BIT_CAUSE_SOFT 11
`define BIT_WD_PERIOD_HI 9
`define BIT_WD_PERIOD_LO 8
`define BIT_SOFT_RESET 4
`define BIT_STAB_HI 3
`define BIT_STAB_LO 2
`define BIT_SYNC_MODE 9

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define STAB_SEL_RESET 2'h0
`define WD_PERIOD_RESET 2'h0
`define SYNC_MODE_RESET 1'b0
`define WD_KEY_FIRST 8'ha5
`define WD_KEY_SECOND 8'h5a
`define MODE_VEC_ADDR 32'h000ffff8
`define BOOT_MODE_ADDR 32'h000007fd
`define RESET_VEC_ADDR 32'h000ffffc

// ----------------------------------------------------------------
// Timing counts in core clock cycles
// ----------------------------------------------------------------
`define STAB_CYC_0 13'h0040
`define STAB_CYC_1 13'h0100
`define STAB_CYC_2 13'h0400
`define STAB_CYC_3 13'h1000
`define WD_CYC_0 13'h0100
`define WD_CYC_1 13'h0200
`define WD_CYC_2 13'h0400
`define WD_CYC_3 13'h0800

`endif

/* File: reset_source_sequencer.v */
// Reset source collection and reset release sequencing.
// Assumes the bus idle input and fetch handshake run on core_clk;
// the external reset pin is asynchronous and is synchronised here.

`timescale 1ns/10ps
`default_nettype none

`include "reset_seq_defines.vh"

module reset_source_sequencer (
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    input wire external_full_reset_pin_n,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire bus_all_stopped,
    output reg bus_sleep_req,
    output reg full_reset,
    output reg op_reset,
    output reg clk_run,
    output reg fetch_req,
    output reg [31:0] fetch_addr,
    input wire [31:0] fetch_data,
    input wire fetch_ack,
    output reg boot_mode_wr,
    output reg [31:0] boot_mode_addr,
    output reg [7:0] boot_mode_data,
    output reg pc_load,
    output reg [31:0] pc_value,
    output reg [1:0] stab_sel,
    output reg sync_reset_mode_bit
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [2:0] ST_INIT = 3'h0;
    localparam [2:0] ST_STAB = 3'h1;
    localparam [2:0] ST_CLKON = 3'h2;
    localparam [2:0] ST_OPRST = 3'h3;
    localparam [2:0] ST_FETCH_MODE = 3'h4;
    localparam [2:0] ST_FETCH_VEC = 3'h5;
    localparam [2:0] ST_RUN = 3'h6;

    // ----------------------------------------------------------------
    // Count lookups
    // ----------------------------------------------------------------
    function [12:0] stab_cycles;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: stab_cycles = `STAB_CYC_0;
                2'h1: stab_cycles = `STAB_CYC_1;
                2'h2: stab_cycles = `STAB_CYC_2;
                default: stab_cycles = `STAB_CYC_3;
            endcase
        end
    endfunction

    function [12:0] wd_cycles;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: wd_cycles = `WD_CYC_0;
                2'h1: wd_cycles = `WD_CYC_1;
                2'h2: wd_cycles = `WD_CYC_2;
                default: wd_cycles = `WD_CYC_3;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    reg pin_meta_r;
    reg pin_sync_r;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else if (clk_en) begin
            pin_meta_r <= external_full_reset_pin_n;
            pin_sync_r <= pin_meta_r;
        end
    end

    wire pin_low = ~pin_sync_r;

    // ----------------------------------------------------------------
    // State and registers
    // ----------------------------------------------------------------
    reg [2:0] state_r;
    reg [12:0] tb_cnt_r;
    reg [12:0] wd_cnt_r;
    reg wd_run_r;
    reg wd_req_r;
    reg wd_key_ok_r;
    reg [1:0] wd_period_r;
    reg soft_pend_r;
    reg flag_pin_r;
    reg flag_watchdog_cause_flag_r;
    reg flag_soft_r;

    wire wr_cause = reg_wr && (reg_addr == `OFS_RESET_CAUSE);
    wire wr_stby = reg_wr && (reg_addr == `OFS_STANDBY_CTRL);
    wire wr_tbc = reg_wr && (reg_addr == `OFS_TIMEBASE_CTRL);
    wire wr_wdp = reg_wr && (reg_addr == `OFS_WD_POSTPONE);
    wire rd_cause = reg_rd && (reg_addr == `OFS_RESET_CAUSE);

    // Pin has precedence; watchdog only when pin is high
    wire init_req = pin_low | wd_req_r;
    wire soft_go = (state_r == ST_RUN) && soft_pend_r && sync_reset_mode_bit
                   && bus_all_stopped;
    wire wd_expire = wd_run_r && (wd_cnt_r == wd_cycles(wd_period_r) - 13'h0001);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_INIT;
            tb_cnt_r <= 13'h0000;
            wd_cnt_r <= 13'h0000;
            wd_run_r <= 1'b0;
            wd_req_r <= 1'b0;
            wd_key_ok_r <= 1'b0;
            wd_period_r <= `WD_PERIOD_RESET;
            soft_pend_r <= 1'b0;
            flag_pin_r <= 1'b0;
            flag_watchdog_cause_flag_r <= 1'b0;
            flag_soft_r <= 1'b0;
            stab_sel <= `STAB_SEL_RESET;
            sync_reset_mode_bit <= `SYNC_MODE_RESET;
            full_reset <= 1'b1;
            op_reset <= 1'b1;
            clk_run <= 1'b0;
            bus_sleep_req <= 1'b0;
            fetch_req <= 1'b0;
            fetch_addr <= 32'h00000000;
            boot_mode_wr <= 1'b0;
            boot_mode_addr <= 32'h00000000;
            boot_mode_data <= 8'h00;
            pc_load <= 1'b0;
            pc_value <= 32'h00000000;
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            // ----------------------------------------------------------
            // Register port
            // ----------------------------------------------------------
            boot_mode_wr <= 1'b0;
            pc_load <= 1'b0;
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    `OFS_RESET_CAUSE: begin
                        reg_rdata[`BIT_CAUSE_PIN] <= flag_pin_r;
                        reg_rdata[`BIT_CAUSE_WATCHDOG_CAUSE_FLAG] <= flag_watchdog_cause_flag_r;
                        reg_rdata[`BIT_CAUSE_SOFT] <= flag_soft_r;
                        reg_rdata[`BIT_WD_PERIOD_HI:`BIT_WD_PERIOD_LO] <= wd_period_r;
                    end
                    `OFS_STANDBY_CTRL: begin
                        reg_rdata[`BIT_SOFT_RESET] <= ~soft_pend_r;
                        reg_rdata[`BIT_STAB_HI:`BIT_STAB_LO] <= stab_sel;
                    end
                    `OFS_TIMEBASE_CTRL: begin
                        reg_rdata[`BIT_SYNC_MODE] <= sync_reset_mode_bit;
                    end
                    default: begin
                        reg_rdata <= 16'h0000;
                    end
                endcase
            end
            // Flags clear on read; a new cause below wins
            if (rd_cause) begin
                flag_pin_r <= 1'b0;
                flag_watchdog_cause_flag_r <= 1'b0;
                flag_soft_r <= 1'b0;
            end
            if (wr_stby) begin
                stab_sel <= reg_wdata[`BIT_STAB_HI:`BIT_STAB_LO];
                if (!reg_wdata[`BIT_SOFT_RESET]) begin
                    soft_pend_r <= 1'b1;
                end
            end
            if (wr_tbc) begin
                sync_reset_mode_bit <= reg_wdata[`BIT_SYNC_MODE];
            end

            // ----------------------------------------------------------
            // Watchdog
            // ----------------------------------------------------------
            if (wd_run_r) begin
                wd_cnt_r <= wd_cnt_r + 13'h0001;
            end
            if (wd_expire) begin
                wd_req_r <= 1'b1;
                wd_run_r <= 1'b0;
            end
            if (wr_wdp) begin
                if (reg_wdata[7:0] == `WD_KEY_FIRST) begin
                    wd_key_ok_r <= 1'b1;
                end else if (wd_key_ok_r && reg_wdata[7:0] == `WD_KEY_SECOND) begin
                    wd_key_ok_r <= 1'b0;
                    if (!wd_expire) begin
                        wd_cnt_r <= 13'h0000;
                    end
                end else begin
                    wd_key_ok_r <= 1'b0;
                end
            end
            if (wr_cause) begin
                wd_period_r <= reg_wdata[`BIT_WD_PERIOD_HI:`BIT_WD_PERIOD_LO];
                wd_run_r <= 1'b1;
                wd_cnt_r <= 13'h0000;
                wd_key_ok_r <= 1'b0;
            end

            // ----------------------------------------------------------
            // Sequencer
            // ----------------------------------------------------------
            bus_sleep_req <= (state_r == ST_RUN) && soft_pend_r
                             && sync_reset_mode_bit && !soft_go;
            case (state_r)
                ST_INIT: begin
                    if (!init_req) begin
                        full_reset <= 1'b0;
                        state_r <= ST_STAB;
                        tb_cnt_r <= 13'h0000;
                    end
                end
                ST_STAB: begin
                    tb_cnt_r <= tb_cnt_r + 13'h0001;
                    if (tb_cnt_r == stab_cycles(stab_sel) - 13'h0001) begin
                        clk_run <= 1'b1;
                        state_r <= ST_CLKON;
                    end
                end
                ST_CLKON: begin
                    op_reset <= 1'b0;
                    fetch_req <= 1'b1;
                    fetch_addr <= `MODE_VEC_ADDR;
                    state_r <= ST_FETCH_MODE;
                end
                ST_OPRST: begin
                    op_reset <= 1'b0;
                    fetch_req <= 1'b1;
                    fetch_addr <= `MODE_VEC_ADDR;
                    state_r <= ST_FETCH_MODE;
                end
                ST_FETCH_MODE: begin
                    if (fetch_ack) begin
                        boot_mode_wr <= 1'b1;
                        boot_mode_addr <= `BOOT_MODE_ADDR;
                        boot_mode_data <= fetch_data[7:0];
                        fetch_addr <= `RESET_VEC_ADDR;
                        state_r <= ST_FETCH_VEC;
                    end
                end
                ST_FETCH_VEC: begin
                    if (fetch_ack) begin
                        fetch_req <= 1'b0;
                        pc_load <= 1'b1;
                        pc_value <= fetch_data;
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (soft_go) begin
                        op_reset <= 1'b1;
                        // A request landing on this very edge stays pending
                        soft_pend_r <= wr_stby && !reg_wdata[`BIT_SOFT_RESET];
                        flag_soft_r <= 1'b1;
                        wd_req_r <= wd_expire;
                        wd_run_r <= 1'b0;
                        wd_key_ok_r <= 1'b0;
                        bus_sleep_req <= 1'b0;
                        state_r <= ST_OPRST;
                    end
                end
                default: begin
                    state_r <= ST_INIT;
                end
            endcase

            // ----------------------------------------------------------
            // Full settings reset overrides the sequencer, watchdog and mode bits above; stab_sel only on a pin cause
            // ----------------------------------------------------------
            if (init_req) begin
                state_r <= ST_INIT;
                full_reset <= 1'b1;
                op_reset <= 1'b1;
                clk_run <= 1'b0;
                bus_sleep_req <= 1'b0;
                fetch_req <= 1'b0;
                boot_mode_wr <= 1'b0;
                pc_load <= 1'b0;
                tb_cnt_r <= 13'h0000;
                sync_reset_mode_bit <= `SYNC_MODE_RESET;
                soft_pend_r <= 1'b0;
                wd_run_r <= 1'b0;
                wd_cnt_r <= 13'h0000;
                wd_key_ok_r <= 1'b0;
                wd_period_r <= `WD_PERIOD_RESET;
                wd_req_r <= 1'b0;
                if (pin_low) begin
                    flag_pin_r <= 1'b1;
                    stab_sel <= `STAB_SEL_RESET;
                end else begin
                    flag_watchdog_cause_flag_r <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

/* File: reset_source_sequencer_bench.sv */
// Self-checking bench for the reset source sequencer.
// Assumes the board model and port checker files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module reset_source_sequencer_bench;
logic core_clk, rst, clk_en, pin_n, reg_wr, reg_rd, bus_all_stopped, pulse_req;
logic [7:0] reg_addr;
logic [15:0] reg_wdata, reg_rdata;
logic [1:0] ack_delay, stab_sel;
logic [31:0] mode_vec, reset_vec, fetch_addr, fetch_data, boot_mode_addr, pc_value;
logic [7:0] boot_mode_data;
logic bus_sleep_req, full_reset, op_reset, clk_run, fetch_req, fetch_ack;
logic boot_mode_wr, pc_load, sync_reset_mode_bit;
logic rd_d = 1'b0;
logic [15:0] rd_q[$];
logic [31:0] pc_q[$];
int fail_count = 0;
int checked = 0;
integer seed = 8915;
reset_source_sequencer i_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .external_full_reset_pin_n(pin_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_all_stopped(bus_all_stopped), .bus_sleep_req(bus_sleep_req),
    .full_reset(full_reset), .op_reset(op_reset), .clk_run(clk_run), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_data(fetch_data), .fetch_ack(fetch_ack),
    .boot_mode_wr(boot_mode_wr), .boot_mode_addr(boot_mode_addr),
    .boot_mode_data(boot_mode_data), .pc_load(pc_load), .pc_value(pc_value),
    .stab_sel(stab_sel), .sync_reset_mode_bit(sync_reset_mode_bit));
board_reset_model i_board (.core_clk(core_clk), .pulse_req(pulse_req), .ack_delay(ack_delay),
    .mode_vec(mode_vec), .reset_vec(reset_vec), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .pin_n(pin_n), .fetch_ack(fetch_ack), .fetch_data(fetch_data));
// ----------------------------------------------------------------
// Tasks
// ----------------------------------------------------------------
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
        fail_count++;
        $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
endtask
task automatic test_done();
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
endtask
task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
endtask
task automatic new_vec();
    logic [31:0] v;
    v = $random(seed);
    reset_vec <= v;
    ack_delay <= v[5:4];
    mode_vec <= $random(seed);
    pc_q.push_back(v);
endtask
task automatic wait_pc(input int lim);
    int n;
    n = 0;
    while (pc_load !== 1'b1 && n < lim) begin
        @(negedge core_clk);
        n++;
    end
    if (n >= lim) chk(32'h0, 32'h1);
    @(posedge core_clk);
endtask
// ----------------------------------------------------------------
// Monitor
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk(32'(reg_rdata), rd_q.size() ? 32'(rd_q.pop_front()) : 32'hx);
    if (pc_load === 1'b1) chk(pc_value, pc_q.size() ? pc_q.pop_front() : 32'hx);
end
// ----------------------------------------------------------------
// Stimulus
// ----------------------------------------------------------------
initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
end
initial begin
    #200000;
    fail_count++;
    test_done();
end
initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    bus_all_stopped = 1'b0;
    pulse_req = 1'b0;
    new_vec();
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wait_pc(3000);
    rd(8'h00, 16'h8000);
    rd(8'h00, 16'h0000);
    rd(8'h10, 16'h0000);
    wr(8'h04, 16'h0014);
    chk(32'(stab_sel), 32'h1);
    clk_en <= 1'b0;
    wr(8'h04, 16'h001c);
    chk(32'(stab_sel), 32'h1);
    clk_en <= 1'b1;
    new_vec();
    wr(8'h04, 16'h0004);
    repeat (20) @(posedge core_clk);
    chk(32'(op_reset), 32'h0);
    rd(8'h04, 16'h0004);
    wr(8'h08, 16'h0200);
    chk(32'(sync_reset_mode_bit), 32'h1);
    repeat (3) @(posedge core_clk);
    chk(32'(bus_sleep_req), 32'h1);
    bus_all_stopped <= 1'b1;
    wait_pc(100);
    bus_all_stopped <= 1'b0;
    rd(8'h00, 16'h0800);
    rd(8'h04, 16'h0014);
    new_vec();
    wr(8'h00, 16'h0100);
    rd(8'h00, 16'h0100);
    repeat (300) @(posedge core_clk);
    wr(8'h0c, 16'h00a5);
    wr(8'h0c, 16'h005a);
    repeat (400) @(posedge core_clk);
    chk(32'(op_reset), 32'h0);
    wait_pc(2000);
    rd(8'h00, 16'h2000);
    chk(32'(stab_sel), 32'h1);
    rd(8'h08, 16'h0000);
    new_vec();
    pulse_req <= 1'b1;
    @(posedge core_clk);
    pulse_req <= 1'b0;
    wait_pc(3000);
    chk(32'(stab_sel), 32'h0);
    rd(8'h00, 16'h8000);
    test_done();
end
endmodule
bind reset_source_sequencer reset_source_sequencer_chk i_chk (.core_clk(core_clk), .rst(rst),
    .external_full_reset_pin_n(external_full_reset_pin_n), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_all_stopped(bus_all_stopped), .bus_sleep_req(bus_sleep_req),
    .full_reset(full_reset), .op_reset(op_reset), .clk_run(clk_run), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_data(fetch_data), .fetch_ack(fetch_ack),
    .boot_mode_wr(boot_mode_wr), .boot_mode_addr(boot_mode_addr),
    .boot_mode_data(boot_mode_data), .pc_load(pc_load), .pc_value(pc_value),
    .stab_sel(stab_sel), .sync_reset_mode_bit(sync_reset_mode_bit));
`default_nettype wire

/* File: reset_source_sequencer_chk.sv */
// Port checker for the reset source sequencer.
// Assumes it is bound to the top module and that clk_en drops only while idle.
`timescale 1ns/10ps
`default_nettype none
module reset_source_sequencer_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic external_full_reset_pin_n,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic bus_all_stopped,
    input wire logic bus_sleep_req,
    input wire logic full_reset,
    input wire logic op_reset,
    input wire logic clk_run,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic [31:0] fetch_data,
    input wire logic fetch_ack,
    input wire logic boot_mode_wr,
    input wire logic [31:0] boot_mode_addr,
    input wire logic [7:0] boot_mode_data,
    input wire logic pc_load,
    input wire logic [31:0] pc_value,
    input wire logic [1:0] stab_sel,
    input wire logic sync_reset_mode_bit
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);
wire [7:0] fd_lo = fetch_data[7:0];
// ----------------------------------------------------------------
// Assertions
// ----------------------------------------------------------------
a_full_op: assert property (full_reset |-> op_reset)
    else $error("op reset low during full reset");
a_pin_full: assert property ((!external_full_reset_pin_n)[*3] |=> full_reset && stab_sel == 2'h0)
    else $error("pin low without full reset or wait reset");
a_stab_hold: assert property ($fell(full_reset) |-> (op_reset && !clk_run)[*8])
    else $error("clock or op reset wrong in wait");
a_clk_first: assert property ($fell(op_reset) |-> $past(clk_run) && clk_run)
    else $error("op reset left before clock ran");
a_first_fetch: assert property ($fell(op_reset) |-> fetch_req && fetch_addr == 32'h000ffff8)
    else $error("mode vector fetch missing");
a_mode_wr: assert property (fetch_ack && fetch_req && fetch_addr == 32'h000ffff8 |=>
    boot_mode_wr && boot_mode_addr == 32'h000007fd && boot_mode_data == $past(fd_lo) &&
    fetch_addr == 32'h000ffffc)
    else $error("mode register write wrong");
a_pc_load: assert property (fetch_ack && fetch_req && fetch_addr == 32'h000ffffc |=>
    pc_load && pc_value == $past(fetch_data) && !fetch_req)
    else $error("program counter load wrong");
a_soft_gate: assert property ($rose(op_reset) && !full_reset |->
    $past(sync_reset_mode_bit) && $past(bus_all_stopped) && $past(bus_sleep_req))
    else $error("soft reset taken without stopped buses");
a_soft_pulse: assert property ($rose(op_reset) && !full_reset |=> !op_reset && fetch_req)
    else $error("soft reset release wrong");
a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
c_pc: cover property (pc_load);
c_soft: cover property ($rose(op_reset) && !full_reset);
c_watchdog_cause_flag: cover property ($rose(full_reset) && external_full_reset_pin_n);
endmodule
`default_nettype wire
